// [rtl/mcp_pkg.sv]
/*
  Constants, types and carriers shared by the metering configuration
  and serial-port lock register bank.
  Assumes one 25 MHz system clock and a synchronous active-high reset.
*/
`default_nettype none

package mcp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Access widths and register addresses
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_HARMONIC_CFG = 16'he900;
  localparam logic [ADDR_W-1:0] ADDR_LPOC_LEVEL   = 16'hec00;
  localparam logic [ADDR_W-1:0] ADDR_SEC_CFG      = 16'hec01;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned PHSEL_LSB   = 8;
  localparam int unsigned PHSEL_MSB   = 9;
  localparam int unsigned HCFG_RSV_LSB = 10;
  localparam int unsigned HCFG_RSV_MSB = 15;
  localparam int unsigned OCL_LSB     = 0;
  localparam int unsigned OCL_MSB     = 2;
  localparam int unsigned LPC_LSB     = 3;
  localparam int unsigned LPC_MSB     = 7;
  localparam int unsigned EXTREF_BIT  = 0;
  localparam int unsigned LOCK_BIT    = 1;
  localparam int unsigned SEC_RSV_LSB = 2;
  localparam int unsigned SEC_RSV_MSB = 7;
  localparam int unsigned REG8_W      = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and port-select constants
  localparam logic [1:0] PHSEL_RST  = 2'h0;
  localparam logic [2:0] OCL_RST    = 3'h7;
  localparam logic [4:0] LPC_RST    = 5'h00;
  localparam logic       EXTREF_RST = 1'h0;

  localparam logic [1:0] SS_TOGGLES     = 2'h3;
  localparam logic [1:0] SS_TOGGLE_LAST = SS_TOGGLES - 2'h1;
  localparam logic [1:0] SS_CNT_RST     = 2'h0;
  localparam logic       SS_IDLE_LVL    = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    PH_A    = 2'b00,
    PH_B    = 2'b01,
    PH_C    = 2'b10,
    PH_RSVD = 2'b11
  } mcp_phase_t;

  typedef enum logic [1:0] {
    PORT_I2C_OPEN   = 2'b00,
    PORT_SPI_OPEN   = 2'b01,
    PORT_I2C_LOCKED = 2'b10,
    PORT_SPI_LOCKED = 2'b11
  } mcp_port_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mcp_req_t;

  typedef struct packed {
    mcp_phase_t time_base_phase_select;
    logic [2:0] overcurrent_threshold_level;
    logic [4:0] low_power_period_count;
    logic       external_reference_select;
  } mcp_cfg_t;

  localparam mcp_cfg_t CFG_RST = '{
    time_base_phase_select:      PH_A,
    overcurrent_threshold_level: OCL_RST,
    low_power_period_count:      LPC_RST,
    external_reference_select:   EXTREF_RST
  };

endpackage

`default_nettype wire

// [rtl/mcp_pin_sync.sv]
/*
  Two-stage synchroniser for an asynchronous pin, with a registered
  falling-edge pulse taken behind the second stage.
  Assumes the pin is quiet for at least two clocks between edges.
*/
`timescale 1ns/1ps
`default_nettype none

module mcp_pin_sync #(
  parameter logic RST_LVL = 1'h1
) (
  input  wire logic i_mclk,    // System clock
  input  wire logic i_sys_rst, // Synchronous reset, high
  input  wire logic i_pin,     // Asynchronous pin
  output var  logic o_level,   // Synchronised level
  output var  logic o_fall     // One-cycle falling-edge pulse
);

  logic meta;
  logic prev;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      meta    <= RST_LVL;
      o_level <= RST_LVL;
    end
    else
    begin
      meta    <= i_pin;
      o_level <= meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect on synchronised level only
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      prev   <= RST_LVL;
      o_fall <= 1'h0;
    end
    else
    begin
      prev   <= o_level;
      o_fall <= prev & ~o_level;
    end
  end

endmodule

`default_nettype wire

// [rtl/mcp_field_reg.sv]
/*
  One writable register field with a reset value.
  Assumes the write enable is a single-cycle strobe on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mcp_field_reg #(
  parameter int unsigned            WIDTH   = 1,
  parameter logic [WIDTH-1:0]       RST_VAL = '0
) (
  input  wire logic             i_mclk,    // System clock
  input  wire logic             i_sys_rst, // Synchronous reset, high
  input  wire logic             i_we,      // Write strobe
  input  wire logic [WIDTH-1:0] i_d,       // Write data
  output var  logic [WIDTH-1:0] o_q        // Stored value
);

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_q <= RST_VAL;
    else if (i_we)
      o_q <= i_d;
  end

endmodule

`default_nettype wire

// [rtl/mcp_regs.sv]
/*
  Configuration register bank of the polyphase meter: time-base phase,
  low-power overcurrent level and period, ADC reference select, and the
  serial-port lock that fixes the host port as I2C or SPI for good.
  Assumes the serial front end hands over decoded register requests on
  the system clock, and that the power-mode code comes from same-clock
  logic. The slave-select pin is asynchronous and is synchronised here.

// Summary of operation
// - Phase select 01 picks phase B, 10 and reserved 11 pick phase C.
// - Phase select sits in bits 9:8, code 00 is phase A, reset 00.
// - Overcurrent level bits 2:0 set threshold at full scale times value/8, reset 111.
// - Period count bits 7:3 give period (value+1)/50 seconds, reset zero.
// - Secondary bit 0 chooses internal reference when 0, external when 1.
// - Unlocked, three slave-select pin toggles switch the device to SPI.
// - After I2C lock, pin toggles are ignored and SPI is never entered.
// - On SPI, any write to the secondary register locks SPI permanently.
// - Locked port choice survives every power-mode change.
// - Harmonic bits 15:10 and secondary bits 7:2 control nothing, reset zero.
*/
`timescale 1ns/1ps
`default_nettype none

module mcp_regs (
  input  wire logic             i_mclk,                 // 25 MHz clock
  input  wire logic             i_sys_rst,              // Synchronous reset
  input  wire mcp_pkg::mcp_req_t i_req,                 // Register request
  input  wire logic             i_slave_select_alt_pin, // Async pin
  input  wire logic [1:0]       i_power_mode_states,    // Power mode code
  output var  mcp_pkg::mcp_cfg_t o_cfg,                 // Configuration
  output var  logic [15:0]      o_rdata,                // Read data
  output var  logic             o_rd_valid,             // Read data pulse
  output var  logic             o_spi_active,           // SPI port chosen
  output var  logic             o_port_locked           // Port choice fixed
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                   wr_hcfg;
  logic                   wr_lpoc;
  logic                   wr_sec;
  logic                   rd_any;
  logic                   lock_wr;
  logic [1:0]             ph_raw;
  logic [2:0]             ocl_q;
  logic [4:0]             lpc_q;
  logic                   ext_q;
  logic                   ss_fall;
  logic [1:0]             tog_cnt;
  logic [1:0]             next_tog_cnt;
  mcp_pkg::mcp_port_t     port_state;
  mcp_pkg::mcp_port_t     next_port_state;
  mcp_pkg::mcp_phase_t    next_phase;
  logic [15:0]            next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_hcfg = i_req.wr && (i_req.addr == mcp_pkg::ADDR_HARMONIC_CFG);
  assign wr_lpoc = i_req.wr && (i_req.addr == mcp_pkg::ADDR_LPOC_LEVEL);
  assign wr_sec  = i_req.wr && (i_req.addr == mcp_pkg::ADDR_SEC_CFG);
  assign rd_any  = i_req.rd;
  assign lock_wr = wr_sec && i_req.wdata[mcp_pkg::LOCK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Stored fields; reserved bits have no storage
  mcp_field_reg #(
    .WIDTH   (2),
    .RST_VAL (mcp_pkg::PHSEL_RST)
  ) u_phase (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_we      (wr_hcfg),
    .i_d       (i_req.wdata[mcp_pkg::PHSEL_MSB:mcp_pkg::PHSEL_LSB]),
    .o_q       (ph_raw)
  );

  mcp_field_reg #(
    .WIDTH   (3),
    .RST_VAL (mcp_pkg::OCL_RST)
  ) u_ocl (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_we      (wr_lpoc),
    .i_d       (i_req.wdata[mcp_pkg::OCL_MSB:mcp_pkg::OCL_LSB]),
    .o_q       (ocl_q)
  );

  mcp_field_reg #(
    .WIDTH   (5),
    .RST_VAL (mcp_pkg::LPC_RST)
  ) u_lpc (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_we      (wr_lpoc),
    .i_d       (i_req.wdata[mcp_pkg::LPC_MSB:mcp_pkg::LPC_LSB]),
    .o_q       (lpc_q)
  );

  mcp_field_reg #(
    .WIDTH   (1),
    .RST_VAL (mcp_pkg::EXTREF_RST)
  ) u_ext (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_we      (wr_sec),
    .i_d       (i_req.wdata[mcp_pkg::EXTREF_BIT]),
    .o_q       (ext_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slave-select pin, idle high
  mcp_pin_sync #(
    .RST_LVL (mcp_pkg::SS_IDLE_LVL)
  ) u_ss_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_slave_select_alt_pin),
    .o_level   (),
    .o_fall    (ss_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Time-base phase decode, reserved code falls back to phase C
  always_comb
  begin
    unique case (mcp_pkg::mcp_phase_t'(ph_raw))
      mcp_pkg::PH_A:    next_phase = mcp_pkg::PH_A;
      mcp_pkg::PH_B:    next_phase = mcp_pkg::PH_B;
      mcp_pkg::PH_C:    next_phase = mcp_pkg::PH_C;
      mcp_pkg::PH_RSVD: next_phase = mcp_pkg::PH_C;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_cfg <= mcp_pkg::CFG_RST;
    else
    begin
      o_cfg.time_base_phase_select      <= next_phase;
      o_cfg.overcurrent_threshold_level <= ocl_q;
      o_cfg.low_power_period_count      <= lpc_q;
      o_cfg.external_reference_select   <= ext_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial-port selection and lock
  always_comb
  begin
    next_port_state = port_state;
    next_tog_cnt    = tog_cnt;
    unique case (port_state)
      mcp_pkg::PORT_I2C_OPEN:
      begin
        if (lock_wr)
        begin
          next_port_state = mcp_pkg::PORT_I2C_LOCKED;
          next_tog_cnt    = mcp_pkg::SS_CNT_RST;
        end
        else if (ss_fall && (tog_cnt == mcp_pkg::SS_TOGGLE_LAST))
        begin
          next_port_state = mcp_pkg::PORT_SPI_OPEN;
          next_tog_cnt    = mcp_pkg::SS_CNT_RST;
        end
        else if (ss_fall)
          next_tog_cnt = tog_cnt + 2'h1;
      end
      mcp_pkg::PORT_SPI_OPEN:
      begin
        if (wr_sec)
          next_port_state = mcp_pkg::PORT_SPI_LOCKED;
      end
      mcp_pkg::PORT_I2C_LOCKED:
        next_port_state = mcp_pkg::PORT_I2C_LOCKED;
      mcp_pkg::PORT_SPI_LOCKED:
        next_port_state = mcp_pkg::PORT_SPI_LOCKED;
    endcase
  end

  // Only reset leaves a locked state; power modes do not touch it
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      port_state    <= mcp_pkg::PORT_I2C_OPEN;
      tog_cnt       <= mcp_pkg::SS_CNT_RST;
      o_spi_active  <= 1'h0;
      o_port_locked <= 1'h0;
    end
    else
    begin
      port_state    <= next_port_state;
      tog_cnt       <= next_tog_cnt;
      o_spi_active  <= (next_port_state == mcp_pkg::PORT_SPI_OPEN)
                    || (next_port_state == mcp_pkg::PORT_SPI_LOCKED);
      o_port_locked <= (next_port_state == mcp_pkg::PORT_I2C_LOCKED)
                    || (next_port_state == mcp_pkg::PORT_SPI_LOCKED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved and unmapped bits return zero
  always_comb
  begin
    next_rdata = '0;
    if (i_req.addr == mcp_pkg::ADDR_HARMONIC_CFG)
      next_rdata[mcp_pkg::PHSEL_MSB:mcp_pkg::PHSEL_LSB] = ph_raw;
    else if (i_req.addr == mcp_pkg::ADDR_LPOC_LEVEL)
    begin
      next_rdata[mcp_pkg::OCL_MSB:mcp_pkg::OCL_LSB] = ocl_q;
      next_rdata[mcp_pkg::LPC_MSB:mcp_pkg::LPC_LSB] = lpc_q;
    end
    else if (i_req.addr == mcp_pkg::ADDR_SEC_CFG)
    begin
      next_rdata[mcp_pkg::EXTREF_BIT] = ext_q;
      next_rdata[mcp_pkg::LOCK_BIT]   = (port_state == mcp_pkg::PORT_I2C_LOCKED)
                                     || (port_state == mcp_pkg::PORT_SPI_LOCKED);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_rdata    <= '0;
      o_rd_valid <= 1'h0;
    end
    else
    begin
      o_rd_valid <= rd_any;
      if (rd_any)
        o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_third_toggle;
    (port_state == mcp_pkg::PORT_I2C_OPEN) && !lock_wr && ss_fall
      && (tog_cnt == mcp_pkg::SS_TOGGLE_LAST);
  endsequence

  sequence s_sec_write_ext;
    wr_sec ##1 1'b1;
  endsequence

  sequence s_spi_lock_write;
    (port_state == mcp_pkg::PORT_SPI_OPEN) && wr_sec;
  endsequence

  sequence s_sec_read;
    rd_any && (i_req.addr == mcp_pkg::ADDR_SEC_CFG);
  endsequence

  AST_PHASE_RSVD: assert property (
    (ph_raw == mcp_pkg::PH_RSVD) |=> (o_cfg.time_base_phase_select == mcp_pkg::PH_C))
    else $error("reserved phase code did not select phase C");

  AST_PHASE_B: assert property (
    (ph_raw == mcp_pkg::PH_B) |=> (o_cfg.time_base_phase_select == mcp_pkg::PH_B))
    else $error("phase code 01 did not select phase B");

  AST_PHASE_RESET: assert property (
    $past(i_sys_rst) |-> (ph_raw == mcp_pkg::PHSEL_RST)
      && (o_cfg.time_base_phase_select == mcp_pkg::PH_A))
    else $error("phase select not at phase A after reset");

  AST_LEVEL_RESET: assert property (
    $past(i_sys_rst) |-> (ocl_q == mcp_pkg::OCL_RST) && (lpc_q == mcp_pkg::LPC_RST))
    else $error("low-power level fields wrong after reset");

  AST_LEVEL_WRITE: assert property (
    wr_lpoc |=> ##1
      (o_cfg.overcurrent_threshold_level
        == $past(i_req.wdata[mcp_pkg::OCL_MSB:mcp_pkg::OCL_LSB], 2))
      && (o_cfg.low_power_period_count
        == $past(i_req.wdata[mcp_pkg::LPC_MSB:mcp_pkg::LPC_LSB], 2)))
    else $error("low-power level write not reflected");

  AST_EXTREF_WRITE: assert property (
    s_sec_write_ext |=>
      (o_cfg.external_reference_select == $past(i_req.wdata[mcp_pkg::EXTREF_BIT], 2)))
    else $error("reference select write not reflected");

  AST_SPI_SWITCH: assert property (
    s_third_toggle |=> o_spi_active && !o_port_locked)
    else $error("third pin toggle did not select SPI");

  AST_I2C_HOLD: assert property (
    (port_state == mcp_pkg::PORT_I2C_LOCKED) |=> !o_spi_active
      && (port_state == mcp_pkg::PORT_I2C_LOCKED))
    else $error("locked I2C port left or switched to SPI");

  AST_SPI_LOCK: assert property (
    s_spi_lock_write |=> o_port_locked && o_spi_active
      ##1 (port_state == mcp_pkg::PORT_SPI_LOCKED))
    else $error("SPI write to secondary register did not lock");

  AST_LOCK_KEEP: assert property (
    o_port_locked && $changed(i_power_mode_states) |=>
      o_port_locked && $stable(o_spi_active))
    else $error("port lock changed across power mode change");

  AST_RSVD_ZERO: assert property (
    s_sec_read |=> o_rd_valid
      && (o_rdata[mcp_pkg::SEC_RSV_MSB:mcp_pkg::SEC_RSV_LSB] == '0)
      && (o_rdata[15:mcp_pkg::REG8_W] == '0))
    else $error("reserved secondary bits not zero");

  AST_HCFG_RSVD: assert property (
    rd_any && (i_req.addr == mcp_pkg::ADDR_HARMONIC_CFG) |=>
      (o_rdata[mcp_pkg::HCFG_RSV_MSB:mcp_pkg::HCFG_RSV_LSB] == '0))
    else $error("reserved harmonic bits not zero");

endmodule

`default_nettype wire

// [tb/mcp_host_model.sv]
/*
  Host microcontroller model: issues register requests on the decoded
  request carrier and toggles the slave-select pin.
  Assumes the bench calls its tasks; all changes land on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module mcp_host_model (
  input  wire logic              i_mclk,     // System clock
  input  wire logic              i_rd_valid, // Read data pulse
  input  wire logic [15:0]       i_rdata,    // Read data
  output var  mcp_pkg::mcp_req_t o_req,      // Register request
  output var  logic              o_pin       // Slave-select pin
);
  initial
  begin
    o_req = '0;
    o_pin = 1'h1;
  end

  // Address and data are inverted once released so stale values never look valid
  task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_mclk);
    o_req.wr = 1'h1;
    o_req.addr = a;
    o_req.wdata = d;
    @(negedge i_mclk);
    o_req.wr = 1'h0;
    o_req.addr = ~a;
    o_req.wdata = ~d;
  endtask

  task automatic bus_read(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(negedge i_mclk);
    o_req.rd = 1'h1;
    o_req.addr = a;
    @(negedge i_mclk);
    d = i_rdata;
    v = i_rd_valid;
    o_req.rd = 1'h0;
    o_req.addr = ~a;
  endtask

  // One toggle is one falling edge, with the pin held low and high long enough
  task automatic toggle();
    @(negedge i_mclk);
    o_pin = 1'h0;
    repeat (3) @(negedge i_mclk);
    o_pin = 1'h1;
    repeat (3) @(negedge i_mclk);
  endtask

  task automatic lock_i2c();
    bus_write(mcp_pkg::ADDR_SEC_CFG, 16'h0002);
  endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
  Self-checking bench for the configuration and port-lock register bank.
  Assumes the host model in tb/ and the package and design in rtl/.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic              mclk;
  logic              sys_rst;
  logic [1:0]        pmode;
  mcp_pkg::mcp_req_t req;
  logic              pin;
  mcp_pkg::mcp_cfg_t cfg;
  logic [15:0]       rdata;
  logic              rd_valid;
  logic              spi_active;
  logic              port_locked;
  int                n_mismatch = 0;
  int                samples_checked = 0;

  mcp_regs DUT (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_req(req), .i_slave_select_alt_pin(pin),
    .i_power_mode_states(pmode), .o_cfg(cfg), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_spi_active(spi_active), .o_port_locked(port_locked)
  );

  mcp_host_model host (
    .i_mclk(mclk), .i_rd_valid(rd_valid), .i_rdata(rdata), .o_req(req), .o_pin(pin)
  );

  initial
  begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.bus_read(a, d, v);
    check({what, " valid"}, 16'h1, 16'(v));
    check(what, exp, d);
  endtask

  task automatic ports_chk(input logic spi, input logic lck);
    check("spi active", 16'(spi), 16'(spi_active));
    check("port locked", 16'(lck), 16'(port_locked));
  endtask

  task automatic do_reset();
    @(negedge mclk);
    sys_rst = 1'h1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("cfg", 16'(mcp_pkg::CFG_RST), 16'(cfg));
    check("level", 16'h7, 16'(cfg.overcurrent_threshold_level));
    ports_chk(1'h0, 1'h0);
    rd_chk("hcfg", mcp_pkg::ADDR_HARMONIC_CFG, 16'h0000);
    rd_chk("lpoc", mcp_pkg::ADDR_LPOC_LEVEL, 16'h0007);
    rd_chk("sec", mcp_pkg::ADDR_SEC_CFG, 16'h0000);
    rd_chk("unmapped", 16'hec02, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_phase();
    for (int c = 0; c < 4; c++)
    begin
      host.bus_write(mcp_pkg::ADDR_HARMONIC_CFG, 16'hfcff | (16'(c) << 8));
      @(negedge mclk);
      check("phase", (c == 3) ? 16'h2 : 16'(c), 16'(cfg.time_base_phase_select));
      rd_chk("hcfg", mcp_pkg::ADDR_HARMONIC_CFG, 16'(c) << 8);
    end
    $display("test phase done");
  endtask

  task automatic t_level();
    logic [15:0] d;
    for (int i = 0; i < 2; i++)
    begin
      d = (i == 0) ? 16'hffa5 : 16'h00ff;
      host.bus_write(mcp_pkg::ADDR_LPOC_LEVEL, d);
      @(negedge mclk);
      check("level", 16'(d[2:0]), 16'(cfg.overcurrent_threshold_level));
      check("period", 16'(d[7:3]), 16'(cfg.low_power_period_count));
      rd_chk("lpoc", mcp_pkg::ADDR_LPOC_LEVEL, {8'h00, d[7:0]});
    end
    $display("test level done");
  endtask

  task automatic t_refsel();
    host.bus_write(mcp_pkg::ADDR_SEC_CFG, 16'hfffd);
    @(negedge mclk);
    check("ext ref", 16'h1, 16'(cfg.external_reference_select));
    ports_chk(1'h0, 1'h0);
    rd_chk("sec", mcp_pkg::ADDR_SEC_CFG, 16'h0001);
    host.bus_write(mcp_pkg::ADDR_SEC_CFG, 16'h0000);
    @(negedge mclk);
    check("ext ref", 16'h0, 16'(cfg.external_reference_select));
    $display("test refsel done");
  endtask

  task automatic t_i2c_lock();
    do_reset();
    host.lock_i2c();
    @(negedge mclk);
    ports_chk(1'h0, 1'h1);
    host.bus_write(mcp_pkg::ADDR_SEC_CFG, 16'h0000);
    repeat (3) host.toggle();
    for (int m = 1; m < 4; m++)
    begin
      pmode = 2'(m);
      @(negedge mclk);
      ports_chk(1'h0, 1'h1);
    end
    rd_chk("sec", mcp_pkg::ADDR_SEC_CFG, 16'h0002);
    $display("test i2c lock done");
  endtask

  task automatic t_spi_lock();
    do_reset();
    pmode = 2'h0;
    repeat (2) host.toggle();
    ports_chk(1'h0, 1'h0);
    host.toggle();
    ports_chk(1'h1, 1'h0);
    host.bus_write(mcp_pkg::ADDR_SEC_CFG, 16'h0001);
    @(negedge mclk);
    ports_chk(1'h1, 1'h1);
    for (int m = 3; m >= 0; m--)
    begin
      pmode = 2'(m);
      @(negedge mclk);
      ports_chk(1'h1, 1'h1);
    end
    repeat (3) host.toggle();
    ports_chk(1'h1, 1'h1);
    rd_chk("sec", mcp_pkg::ADDR_SEC_CFG, 16'h0003);
    $display("test spi lock done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'h1;
    pmode = 2'h0;
    repeat (4) @(negedge mclk);
    sys_rst = 1'h0;
    t_reset();
    t_phase();
    t_level();
    t_refsel();
    t_i2c_lock();
    t_spi_lock();
    results();
  end

  initial
  begin
    #(40 * 2000);
    n_mismatch++;
    results();
  end
endmodule

`default_nettype wire
